//--- core/ies_status.sv
/*
  Condition register, per-bit transition filter, extended event register,
  output queue and error queue behind an Avalon-MM slave.
  Assumes status inputs are asynchronous pins; response and error pushes come
  from logic on clk.
*/
// Local design decisions: register access over Avalon-MM and the placing of the registers.
`timescale 1ns/10ps
`include "ies_params.svh"
module ies_status
  import ies_pkg::*;
#(
  parameter int SCG_CYCLES = `IES_SCG_CYCLES,
  parameter int OQ_AW      = 4,
  parameter int EQ_AW      = 4
) (
  // Clock and reset.
  input  wire logic        clk,
  input  wire logic        rst_n,
  // Instrument state pins.
  input  wire logic        sweep_running,
  input  wire logic        output_on,
  input  wire logic        output_value_changed,
  input  wire logic        ext_junction_valid,
  input  wire logic        int_junction_valid,
  input  wire logic        fan_stopped,
  input  wire logic        overtemp_fault,
  input  wire logic        supply_fault,
  input  wire logic        output_control_fault,
  input  wire logic        amp_oscillation,
  input  wire logic        overvoltage_load,
  input  wire logic        overcurrent_input,
  input  wire logic        junction_sensor_attached,
  // Query responses and errors.
  input  wire logic        resp_push,
  input  wire logic [15:0] resp_data,
  input  wire logic        err_push,
  input  wire logic [15:0] err_code,
  // Avalon-MM slave.
  input  wire logic [3:0]  address,
  input  wire logic        read,
  input  wire logic        write,
  input  wire logic [31:0] writedata,
  input  wire logic [3:0]  byteenable,
  output logic      [31:0] readdata,
  output logic             waitrequest,
  // Summary bits.
  output logic      [7:0]  summary
);
  // ************************************************************
  // Input synchronisers.
  // ************************************************************
  logic [15:0] pins;
  logic [15:0] sync1_r;
  logic [15:0] sync2_r;
  logic [15:0] cond_r;
  logic        chg_s1_r;
  logic        chg_s2_r;
  logic        chg_d_r;
  assign pins = {junction_sensor_attached, overcurrent_input, 1'b0, overvoltage_load,
                 amp_oscillation, output_control_fault, 1'b0, supply_fault,
                 overtemp_fault, 1'b0, fan_stopped, int_junction_valid,
                 1'b0, ext_junction_valid, output_on, sweep_running};
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      sync1_r  <= '0;
      sync2_r  <= '0;
      chg_s1_r <= 1'b0;
      chg_s2_r <= 1'b0;
      chg_d_r  <= 1'b0;
    end else begin
      sync1_r  <= pins;
      sync2_r  <= sync1_r;
      chg_s1_r <= output_value_changed;
      chg_s2_r <= chg_s1_r;
      chg_d_r  <= chg_s2_r;
    end
  end

  // ************************************************************
  // Source change timer.
  // ************************************************************
  logic [31:0] scg_cnt_r;
  logic        out_rise;
  logic        val_chg;
  logic        scg_bit;
  assign out_rise = sync2_r[1] && !cond_r[1];
  assign val_chg  = chg_s2_r && !chg_d_r;
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      scg_cnt_r <= '0;
    end else if (out_rise || val_chg) begin
      scg_cnt_r <= 32'(SCG_CYCLES);
    end else if (scg_cnt_r != '0) begin
      scg_cnt_r <= scg_cnt_r - 32'h1;
    end
  end
  assign scg_bit = (scg_cnt_r != '0);

  // ************************************************************
  // Condition and extended event registers.
  // ************************************************************
  logic [15:0] cond_nxt;
  logic [15:0] event_r;
  logic [15:0] enable_r;
  logic [31:0] filt_r;
  logic [15:0] ev_set;
  logic [15:0] ev_clr;
  logic        ev_wclr;
  always_comb begin
    cond_nxt = sync2_r & `IES_COND_USED;
    cond_nxt[`IES_BIT_SCG] = scg_bit;
  end
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      cond_r <= '0;
    end else begin
      cond_r <= cond_nxt;
    end
  end
  always_comb begin
    ev_set = '0;
    ev_clr = '0;
    for (int i = 0; i < 16; i++) begin
      case (ies_filt_t'(filt_r[2*i +: 2]))
        IES_FILT_RISE: begin
          ev_clr[i] = cond_nxt[i] && !cond_r[i];
        end
        IES_FILT_FALL: begin
          ev_set[i] = !cond_nxt[i] && cond_r[i];
        end
        IES_FILT_BOTH: begin
          ev_set[i] = cond_nxt[i] != cond_r[i];
        end
        default: begin
          ev_clr[i] = 1'b1;
        end
      endcase
    end
    ev_set = ev_set & `IES_COND_USED;
  end
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      event_r <= '0;
    end else begin
      event_r <= ((ev_wclr ? 16'h0 : event_r) & ~ev_clr) | ev_set;
    end
  end

  // ************************************************************
  // Bus slave.
  // ************************************************************
  ies_bus_t    bus_r;
  logic [31:0] be_mask;
  logic        wr_hit;
  logic        rd_go;
  logic [15:0] oq_head;
  logic [15:0] eq_head;
  logic        oq_ne;
  logic        eq_ne;
  logic        oq_pop;
  logic        eq_pop;
  logic        oq_flush;
  logic        eq_flush;
  logic [31:0] rd_mux;
  assign be_mask = {{8{byteenable[3]}}, {8{byteenable[2]}},
                    {8{byteenable[1]}}, {8{byteenable[0]}}};
  assign wr_hit  = write && (bus_r == IES_BUS_IDLE);
  assign rd_go   = read && (bus_r == IES_BUS_IDLE);
  assign ev_wclr = wr_hit && address == `IES_REG_EVENT;
  assign oq_pop  = rd_go && address == `IES_REG_OQ && oq_ne;
  assign eq_pop  = rd_go && address == `IES_REG_EQ && eq_ne;
  assign oq_flush = wr_hit && address == `IES_REG_CTRL &&
                    (writedata[`IES_CTRL_NEWMSG] || writedata[`IES_CTRL_DEADLK] ||
                     writedata[`IES_CTRL_DCL]);
  assign eq_flush = wr_hit && address == `IES_REG_CTRL && writedata[`IES_CTRL_CLS];
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      bus_r <= IES_BUS_IDLE;
    end else begin
      case (bus_r)
        IES_BUS_IDLE: begin
          if (read || write) begin
            bus_r <= IES_BUS_WAIT;
          end
        end
        IES_BUS_WAIT: begin
          bus_r <= IES_BUS_DONE;
        end
        IES_BUS_DONE: begin
          bus_r <= IES_BUS_IDLE;
        end
        default: begin
          bus_r <= IES_BUS_IDLE;
        end
      endcase
    end
  end
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      waitrequest <= 1'b1;
    end else begin
      waitrequest <= !(bus_r == IES_BUS_WAIT);
    end
  end
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      filt_r   <= '0;
      enable_r <= '0;
    end else if (wr_hit) begin
      case (address)
        `IES_REG_FILT_LO: begin
          filt_r[15:0] <= (filt_r[15:0] & ~be_mask[15:0]) | (writedata[15:0] & be_mask[15:0]);
        end
        `IES_REG_FILT_HI: begin
          filt_r[31:16] <= (filt_r[31:16] & ~be_mask[15:0]) | (writedata[15:0] & be_mask[15:0]);
        end
        `IES_REG_ENABLE: begin
          enable_r <= (enable_r & ~be_mask[15:0]) | (writedata[15:0] & be_mask[15:0]);
        end
        default: begin
          enable_r <= enable_r;
        end
      endcase
    end
  end
  always_comb begin
    case (address)
      `IES_REG_COND:    rd_mux = {16'h0, cond_r};
      `IES_REG_FILT_LO: rd_mux = {16'h0, filt_r[15:0]};
      `IES_REG_FILT_HI: rd_mux = {16'h0, filt_r[31:16]};
      `IES_REG_EVENT:   rd_mux = {16'h0, event_r};
      `IES_REG_ENABLE:  rd_mux = {16'h0, enable_r};
      `IES_REG_SUMMARY: rd_mux = {24'h0, summary};
      `IES_REG_OQ:      rd_mux = {15'h0, oq_ne, oq_ne ? oq_head : 16'h0};
      `IES_REG_EQ:      rd_mux = {15'h0, eq_ne, eq_ne ? eq_head : 16'h0};
      default:          rd_mux = 32'h0;
    endcase
  end
  logic [31:0] rd_hold_r;
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      rd_hold_r <= '0;
      readdata  <= '0;
    end else begin
      if (rd_go) begin
        rd_hold_r <= rd_mux;
      end
      if (bus_r == IES_BUS_WAIT) begin
        readdata <= rd_hold_r;
      end
    end
  end

  // ************************************************************
  // Queues and summary.
  // ************************************************************
  ies_queue #(.AW(OQ_AW), .DW(16), .OVF_MARK(1'b0)) u_oq (
    .clk       (clk),
    .rst_n     (rst_n),
    .flush     (oq_flush),
    .push      (resp_push),
    .push_data (resp_data),
    .pop       (oq_pop),
    .head      (oq_head),
    .not_empty (oq_ne)
  );
  ies_queue #(.AW(EQ_AW), .DW(16), .OVF_MARK(1'b1)) u_eq (
    .clk       (clk),
    .rst_n     (rst_n),
    .flush     (eq_flush),
    .push      (err_push),
    .push_data (err_code),
    .pop       (eq_pop),
    .head      (eq_head),
    .not_empty (eq_ne)
  );
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      summary <= '0;
    end else begin
      summary <= '0;
      summary[`IES_SUM_EES] <= |(event_r & enable_r);
      summary[`IES_SUM_MAV] <= oq_ne;
      summary[`IES_SUM_EAV] <= eq_ne;
    end
  end

  // ************************************************************
  // Assertions.
  // ************************************************************
  unused_bits_a: assert property (@(posedge clk) disable iff (!rst_n)
    (cond_r & ~`IES_COND_USED) == 16'h0 && (event_r & ~`IES_COND_USED) == 16'h0)
    else $error("unused bits nonzero");
  never_mode_a: assert property (@(posedge clk) disable iff (!rst_n)
    (filt_r[1:0] == 2'h0) |=> !event_r[0]) else $error("never mode event");
  fall_set_a: assert property (@(posedge clk) disable iff (!rst_n)
    (filt_r[1:0] == 2'h2 && cond_r[0] && !cond_nxt[0]) |=> event_r[0])
    else $error("fall not set");
  both_set_a: assert property (@(posedge clk) disable iff (!rst_n)
    (filt_r[1:0] == 2'h3 && $changed(cond_nxt[0])) |=> event_r[0])
    else $error("both not set");
  rise_clr_a: assert property (@(posedge clk) disable iff (!rst_n)
    (filt_r[1:0] == 2'h1 && !cond_r[0] && cond_nxt[0]) |=> !event_r[0])
    else $error("rise not cleared");
  ees_sum_a: assert property (@(posedge clk) disable iff (!rst_n)
    |(event_r & enable_r) |=> summary[`IES_SUM_EES]) else $error("summary ees");
  mav_sum_a: assert property (@(posedge clk) disable iff (!rst_n)
    summary[`IES_SUM_MAV] == $past(oq_ne)) else $error("summary mav");
  eav_sum_a: assert property (@(posedge clk) disable iff (!rst_n)
    summary[`IES_SUM_EAV] == $past(eq_ne)) else $error("summary eav");
  cls_keep_a: assert property (@(posedge clk) disable iff (!rst_n)
    (eq_flush && !oq_flush && oq_ne && !oq_pop) |=> ##1 oq_ne) else $error("cls cleared oq");
  scg_drop_a: assert property (@(posedge clk) disable iff (!rst_n)
    (scg_cnt_r == 32'h1 && !out_rise && !val_chg) |=> ##1 !cond_r[`IES_BIT_SCG])
    else $error("scg not dropped");
endmodule

//--- shared/ies_params.svh
/*
  Constants for the instrument event and status queue block: register offsets,
  condition bit positions, summary and control bit positions, the overflow error code and timing counts.
  Assumes inclusion by bare name from the design modules and the test bench.
*/
// Overview of operation
// - Condition bit 0 is one while a sweep runs, zero while held.
// - Condition bit 1 follows the source output on state.
// - Bits 2 and 4 show external and internal junction readings in range.
// - Bit 3 rises on output on or value change, drops after 500 ms.
// - Bits 5, 7, 8 show fan stop, overtemperature and supply fault.
// - Bits 10, 11, 12, 14 show control, oscillation, overvoltage, overcurrent faults.
// - Bit 15 shows an external junction sensor is attached.
// - Each condition bit has its own selectable transition filter mode.
// - Rising mode writes the event bit to zero on a 0-to-1 change.
// - Falling mode sets the event bit on a 1-to-0 change.
// - Both mode sets the event bit on any change.
// - Summary bit 3 is high when any event bit and its enable are set.
// - Each query response pushed while the output queue is not full waits there until read.
// - Output messages leave oldest first.
// - Output queue empties on new message, deadlock, device clear or restart.
// - Clear-status leaves the output queue intact.
// - Summary bit 4 shows the output queue is not empty.
// - Each detected error pushes its number into the error queue.
// - Error entries are read back oldest first.
// - On overflow the newest entry becomes error code 350.
// - Error queue empties only on clear-status or restart.
// - Summary bit 2 shows the error queue is not empty.
`ifndef IES_PARAMS_SVH
`define IES_PARAMS_SVH
`define IES_REG_COND     4'h0
`define IES_REG_FILT_LO  4'h1
`define IES_REG_FILT_HI  4'h2
`define IES_REG_EVENT    4'h3
`define IES_REG_ENABLE   4'h4
`define IES_REG_SUMMARY  4'h5
`define IES_REG_OQ       4'h6
`define IES_REG_EQ       4'h7
`define IES_REG_CTRL     4'h8
`define IES_COND_USED    16'hddbf
`define IES_BIT_SCG      3
`define IES_SUM_EAV      2
`define IES_SUM_EES      3
`define IES_SUM_MAV      4
`define IES_ERR_OVF      16'h015e
`define IES_CTRL_CLS     0
`define IES_CTRL_NEWMSG  1
`define IES_CTRL_DEADLK  2
`define IES_CTRL_DCL     3
`define IES_SCG_MS       500
`define IES_CLK_MHZ      250
`define IES_SCG_CYCLES   (`IES_SCG_MS * 1000 * `IES_CLK_MHZ)
`endif

//--- shared/ies_pkg.sv
/*
  Types for the instrument event and status queue block.
  Assumes ies_params.svh is on the include path.
*/
package ies_pkg;
  typedef enum logic [1:0] {
    IES_FILT_NEVER = 2'h0,
    IES_FILT_RISE  = 2'h1,
    IES_FILT_FALL  = 2'h2,
    IES_FILT_BOTH  = 2'h3
  } ies_filt_t;
  typedef enum logic [2:0] {
    IES_BUS_IDLE = 3'h1,
    IES_BUS_WAIT = 3'h2,
    IES_BUS_DONE = 3'h4
  } ies_bus_t;
endpackage

//--- core/ies_ram.sv
/*
  Small dual-port memory with registered read data.
  Assumes one clock shared by both ports.
*/
`timescale 1ns/10ps
module ies_ram #(
  parameter int AW = 4,
  parameter int DW = 16
) (
  // Clock.
  input  wire logic          clk,
  // Write port.
  input  wire logic          we,
  input  wire logic [AW-1:0] waddr,
  input  wire logic [DW-1:0] wdata,
  // Read port.
  input  wire logic [AW-1:0] raddr,
  output logic      [DW-1:0] rdata
);
  logic [DW-1:0] mem [0:(1<<AW)-1];
  always_ff @(posedge clk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
  end
  always_ff @(posedge clk) begin
    rdata <= mem[raddr];
  end
endmodule

//--- core/ies_queue.sv
/*
  First-in first-out queue with flush and optional overflow replacement.
  Assumes the caller never pops when empty.
*/
`timescale 1ns/10ps
`include "ies_params.svh"
module ies_queue #(
  parameter int          AW      = 4,
  parameter int          DW      = 16,
  parameter bit          OVF_MARK = 1'b0,
  parameter logic [15:0] OVF_CODE = `IES_ERR_OVF
) (
  // Clock and reset.
  input  wire logic          clk,
  input  wire logic          rst_n,
  // Control.
  input  wire logic          flush,
  input  wire logic          push,
  input  wire logic [DW-1:0] push_data,
  input  wire logic          pop,
  // State.
  output logic      [DW-1:0] head,
  output logic               not_empty
);
  localparam logic [AW:0] FULL = AW'(0) + (AW+1)'(1 << AW);
  logic [AW:0]   cnt_r;
  logic [AW-1:0] wp_r;
  logic [AW-1:0] rp_r;
  logic          full;
  logic          we;
  logic [AW-1:0] waddr;
  logic [DW-1:0] wdata;
  logic [AW-1:0] rnext;
  assign full  = (cnt_r == FULL);
  assign we    = push && (!full || OVF_MARK);
  assign waddr = full ? (wp_r - AW'(1)) : wp_r;
  assign wdata = full ? DW'(OVF_CODE) : push_data;
  assign rnext = pop ? (rp_r + AW'(1)) : rp_r;
  always_ff @(posedge clk) begin
    if (!rst_n || flush) begin
      cnt_r <= '0;
      wp_r  <= '0;
      rp_r  <= '0;
    end else begin
      if (push && !full) begin
        wp_r <= wp_r + AW'(1);
      end
      if (pop) begin
        rp_r <= rp_r + AW'(1);
      end
      cnt_r <= cnt_r + (AW+1)'(push && !full) - (AW+1)'(pop);
    end
  end
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      not_empty <= 1'b0;
    end else begin
      not_empty <= cnt_r != '0;
    end
  end
  ies_ram #(.AW(AW), .DW(DW)) u_ram (
    .clk   (clk),
    .we    (we),
    .waddr (waddr),
    .wdata (wdata),
    .raddr (rnext),
    .rdata (head)
  );
endmodule

//--- verif/ies_ctrl_model.sv
/*
  Remote controller model: hands query responses and error numbers to the
  status block, one word per one-cycle push, one word every two cycles.
  Assumes one clock shared with the status block.
*/
`timescale 1ns/10ps
module ies_ctrl_model (
  // Clock.
  input  wire logic        clk,
  // Pushes into the block.
  output logic             resp_push,
  output logic      [15:0] resp_data,
  output logic             err_push,
  output logic      [15:0] err_code
);
  // **************************************************************
  // Push sequencing.
  // **************************************************************
  initial begin
    resp_push = 1'b0;
    resp_data = 16'h0000;
    err_push  = 1'b0;
    err_code  = 16'h0000;
  end

  // Released data lines show the inverse of the last word.
  task automatic send(input logic e, input logic [15:0] d);
    @(posedge clk);
    if (e) begin
      err_push <= 1'b1;
      err_code <= d;
    end else begin
      resp_push <= 1'b1;
      resp_data <= d;
    end
    @(posedge clk);
    err_push  <= 1'b0;
    resp_push <= 1'b0;
    err_code  <= ~d;
    resp_data <= ~d;
  endtask
endmodule

//--- verif/instrument_event_status_queues_test.sv
/*
  Self-checking bench for the status block: condition bits, filters,
  event summary, output queue and error queue over Avalon-MM.
  Assumes the design package, header and controller model are compiled first.
*/
`timescale 1ns/10ps
`include "ies_params.svh"
module instrument_event_status_queues_test;
  import ies_pkg::*;
  logic        clk;
  logic        rst_n;
  logic [15:0] p;
  logic        resp_push;
  logic [15:0] resp_data;
  logic        err_push;
  logic [15:0] err_code;
  logic [3:0]  address;
  logic        read;
  logic        write;
  logic [31:0] writedata;
  logic [31:0] readdata;
  logic        waitrequest;
  logic [7:0]  summary;
  logic [31:0] q;
  logic [31:0] ex;
  int          miscompares;
  int          comparisons;
  localparam logic [15:0] PM = 16'hddb5;
  localparam ies_filt_t   MODE [4] = '{IES_FILT_NEVER, IES_FILT_FALL,
                                       IES_FILT_RISE, IES_FILT_BOTH};
  localparam logic [15:0] EXP_R [4] = '{16'h0000, 16'h0000, 16'h0000, PM};
  localparam logic [15:0] EXP_F [4] = '{16'h0000, PM, 16'h0000, PM};

  initial clk = 1'b0;
  always #2 clk = ~clk;

  ies_ctrl_model ctl (.clk(clk), .resp_push(resp_push), .resp_data(resp_data),
                      .err_push(err_push), .err_code(err_code));

  ies_status #(.SCG_CYCLES(50)) DUT (
    .clk(clk), .rst_n(rst_n),
    .sweep_running(p[0]), .output_on(p[1]), .output_value_changed(p[3]),
    .ext_junction_valid(p[2]), .int_junction_valid(p[4]), .fan_stopped(p[5]),
    .overtemp_fault(p[7]), .supply_fault(p[8]), .output_control_fault(p[10]),
    .amp_oscillation(p[11]), .overvoltage_load(p[12]), .overcurrent_input(p[14]),
    .junction_sensor_attached(p[15]),
    .resp_push(resp_push), .resp_data(resp_data), .err_push(err_push), .err_code(err_code),
    .address(address), .read(read), .write(write), .writedata(writedata),
    .byteenable(4'hf), .readdata(readdata), .waitrequest(waitrequest), .summary(summary));

  // **************************************************************
  // Shared tasks.
  // **************************************************************
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      miscompares++;
      $display("ERROR at %0t: got %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] wd);
    int n;
    n = 0;
    @(posedge clk);
    address   <= a;
    writedata <= wd;
    write     <= w;
    read      <= ~w;
    do begin
      @(posedge clk);
      n++;
    end while (waitrequest !== 1'b0 && n < 50);
    q = readdata;
    read  <= 1'b0;
    write <= 1'b0;
    if (n >= 50) begin
      miscompares++;
      $display("ERROR at %0t: bus timeout", $time);
    end
  endtask

  task automatic rdc(input logic [3:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0);
    chk(q, exp);
  endtask

  task automatic wt(input int n);
    repeat (n) @(posedge clk);
  endtask

  function automatic logic [15:0] ecode(input int i);
    return (i == 0) ? 16'd113 : 16'h0100 + 16'(i);
  endfunction

  task test_done;
    $display("Comparisons %0d, mismatches %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge clk);
    miscompares++;
    $display("ERROR at %0t: watchdog expired", $time);
    test_done;
  end

  // **************************************************************
  // Stimulus and checks.
  // **************************************************************
  initial begin
    rst_n = 1'b0;
    p = 16'h0000;
    address = 4'h0;
    read = 1'b0;
    write = 1'b0;
    writedata = 32'h0;
    miscompares = 0;
    comparisons = 0;
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    chk({24'h0, summary}, 32'h0);
    rdc(`IES_REG_COND, 32'h0);
    bus(1'b1, `IES_REG_COND, 32'hffff);
    rdc(`IES_REG_COND, 32'h0);
    rdc(4'hf, 32'h0);
    for (int k = 0; k < 16; k++) begin
      p <= 16'h1 << k;
      wt(8);
      ex = (k == 1) ? 32'h000a : {16'h0, (16'h1 << k) & `IES_COND_USED};
      rdc(`IES_REG_COND, ex);
      p <= 16'h0000;
      wt(60);
    end
    bus(1'b1, `IES_REG_ENABLE, 32'h1);
    for (int m = 0; m < 4; m++) begin
      bus(1'b1, `IES_REG_FILT_LO, {16'h0, {8{MODE[m]}}});
      bus(1'b1, `IES_REG_FILT_HI, {16'h0, {8{MODE[m]}}});
      p <= PM;
      wt(8);
      rdc(`IES_REG_EVENT, {16'h0, EXP_R[m]});
      chk({24'h0, summary}, (m == 3) ? 32'h8 : 32'h0);
      bus(1'b1, `IES_REG_EVENT, 32'h0);
      p <= 16'h0000;
      wt(8);
      rdc(`IES_REG_EVENT, {16'h0, EXP_F[m]});
    end
    bus(1'b1, `IES_REG_EVENT, 32'h0);
    for (int i = 0; i < 3; i++) ctl.send(1'b0, 16'ha5a0 + 16'(i));
    wt(3);
    chk({24'h0, summary}, 32'h10);
    bus(1'b1, `IES_REG_CTRL, 32'h1);
    for (int i = 0; i < 3; i++) begin
      rdc(`IES_REG_OQ, {15'h0, 1'b1, 16'ha5a0 + 16'(i)});
    end
    rdc(`IES_REG_OQ, 32'h0);
    chk({24'h0, summary}, 32'h0);
    for (int b = 1; b < 4; b++) begin
      ctl.send(1'b0, 16'h0077);
      wt(3);
      chk({24'h0, summary}, 32'h10);
      bus(1'b1, `IES_REG_CTRL, 32'h1 << b);
      rdc(`IES_REG_OQ, 32'h0);
    end
    for (int i = 0; i < 17; i++) ctl.send(1'b1, ecode(i));
    wt(3);
    chk({24'h0, summary}, 32'h4);
    bus(1'b1, `IES_REG_CTRL, 32'he);
    for (int i = 0; i < 16; i++) begin
      ex = {15'h0, 1'b1, (i == 15) ? `IES_ERR_OVF : ecode(i)};
      rdc(`IES_REG_EQ, ex);
    end
    rdc(`IES_REG_EQ, 32'h0);
    ctl.send(1'b1, 16'h0055);
    bus(1'b1, `IES_REG_CTRL, 32'h1);
    rdc(`IES_REG_EQ, 32'h0);
    wt(3);
    chk({24'h0, summary}, 32'h0);
    ctl.send(1'b0, 16'h0011);
    ctl.send(1'b1, 16'h0022);
    wt(3);
    chk({24'h0, summary}, 32'h14);
    rst_n <= 1'b0;
    wt(3);
    rst_n <= 1'b1;
    rdc(`IES_REG_OQ, 32'h0);
    rdc(`IES_REG_EQ, 32'h0);
    chk({24'h0, summary}, 32'h0);
    test_done;
  end
endmodule
